// *** common/cldc_params.svh ***
`ifndef CLDC_PARAMS_SVH
`define CLDC_PARAMS_SVH

// frame field positions
`define CLDC_RW_BIT 31
`define CLDC_CODE_HI 30
`define CLDC_CODE_LO 27
`define CLDC_CHANNEL_SELECTOR_HI 26
`define CLDC_CHANNEL_SELECTOR_LO 24
// message codes
`define CLDC_CODE_GAIN 4'h2
`define CLDC_CODE_SETPT 4'h3
`define CLDC_CODE_DPER 4'h4
// gain fields
`define CLDC_KP_HI 23
`define CLDC_KP_LO 12
`define CLDC_KI_HI 11
`define CLDC_KI_LO 0
// setpoint frame fields
`define CLDC_HOLD_BIT 23
`define CLDC_STEP_HI 21
`define CLDC_STEP_LO 11
`define CLDC_SETP_HI 10
`define CLDC_SETP_LO 0
// dither period field
`define CLDC_QSTEP_HI 4
`define CLDC_QSTEP_LO 0
// reset values
`define CLDC_GAIN_RST 12'h000
`define CLDC_FIELD11_RST 11'h000
`define CLDC_QSTEP_RST 5'h00
// main period reset values (n divider, m code)
`define CLDC_DIVN_RST 14'h271
`define CLDC_DIVM_RST 2'h0
// dither quarter multiplier
`define CLDC_QUARTERS 7'h04
// last sample index per pwm period for m codes 0, 1 and 2/3
`define CLDC_MLAST_32 10'h01F
`define CLDC_MLAST_64 10'h03F
`define CLDC_MLAST_128 10'h07F

`endif

// *** common/cldc_pkg.sv ***
package cldc_pkg;
  // frame kinds this bank answers
  typedef enum logic [1:0] {
    CLDC_K_GAIN,
    CLDC_K_SETPT,
    CLDC_K_DPER,
    CLDC_K_NONE
  } cldc_kind_t;
  typedef logic [2:0] cldc_channel_selector_t;
  typedef logic [31:0] cldc_frame_t;
endpackage

// *** logic/cldc_step_timer.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "cldc_params.svh"
// pwm period tick from n times m clock cycles
module cldc_step_timer
  import cldc_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // period setting
  input wire logic [13:0] div_n,
  input wire logic [1:0] div_m,
  // one pulse per pwm period
  output logic pwm_tick
);
  logic [13:0] n_cnt_q;
  logic [9:0] m_cnt_q;
  logic [9:0] m_last;
  logic n_wrap;

  // m code to samples per period minus one (current control: 11 -> 128)
  always_comb begin
    case (div_m)
      2'h0: m_last = `CLDC_MLAST_32;
      2'h1: m_last = `CLDC_MLAST_64;
      default: m_last = `CLDC_MLAST_128;
    endcase
  end

  // a zero n is treated as one cycle per sample
  assign n_wrap = (n_cnt_q >= div_n - 14'h0001) || (div_n == 14'h0000);

  // sample spacing counter
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      n_cnt_q <= 14'h0000;
    end else if (n_wrap) begin
      n_cnt_q <= 14'h0000;
    end else begin
      n_cnt_q <= n_cnt_q + 14'h0001;
    end
  end

  // samples per period counter, period is n*m clocks
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      m_cnt_q <= 10'h000;
    end else if (n_wrap) begin
      m_cnt_q <= (m_cnt_q >= m_last) ? 10'h000 : m_cnt_q + 10'h001;
    end
  end

  assign pwm_tick = n_wrap && (m_cnt_q >= m_last);
endmodule
`default_nettype wire

// *** logic/cldc_config_bank.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "cldc_params.svh"
// What this block does
// - frame top bit write, code 0010, channel
// - store 12-bit proportional gain per channel
// - store 12-bit integral gain per channel
// - setpoint frames use message code 0011
// - hold flag keeps regulating when enable drops
// - 11-bit dither step, zero disables dither
// - 11-bit current setpoint, reset zero
// - amplitude is twice step times quarter count
// - dither period frames use code 0100
// - 5-bit quarter step count, zero disables
// - dither period is four quarter counts
// - dither steps advance once per pwm period
module cldc_config_bank
  import cldc_pkg::*;
#(
  parameter int CHANNELS = 8
)
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // decoded frame from the serial transport
  input wire logic frame_valid,
  input wire logic [31:0] frame_in,
  // response word to the transport
  output logic resp_valid,
  output logic [31:0] resp_out,
  // main period settings from the neighbouring message
  input wire logic [13:0] div_n,
  input wire logic [1:0] div_m,
  // enable pin, raw from outside
  input wire logic enable_pin,
  // per-channel values for the control law
  output logic [CHANNELS*12-1:0] prop_gain_flat,
  output logic [CHANNELS*12-1:0] int_gain_flat,
  output logic [CHANNELS*11-1:0] setpoint_flat,
  output logic [CHANNELS-1:0] channel_selector_active,
  output logic [CHANNELS-1:0] dither_on,
  output logic [CHANNELS*18-1:0] dither_pp_flat,
  output logic [CHANNELS*7-1:0] dither_period_flat,
  output logic pwm_tick
);
  // ****************************************
  // storage
  // ****************************************
  // loop gains, one pair per channel
  logic [11:0] prop_gain_q [CHANNELS];
  logic [11:0] int_gain_q [CHANNELS];
  // current setpoint and dither step per channel
  logic [10:0] setpoint_q [CHANNELS];
  logic [10:0] dstep_q [CHANNELS];
  // keep running while the enable pin is low
  logic hold_q [CHANNELS];
  // dither steps per quarter wave
  logic [4:0] qsteps_q [CHANNELS];
  // enable pin sampling chain and settled level
  logic [2:0] en_sync_q;
  logic enable_q;
  // registered answer to the transport
  logic [31:0] resp_q;
  logic resp_valid_q;

  // ****************************************
  // frame decode
  // ****************************************
  // header fields of the frame in flight
  logic [3:0] code;
  logic [2:0] channel_selector;
  logic is_write;
  cldc_kind_t kind;

  assign code = frame_in[`CLDC_CODE_HI:`CLDC_CODE_LO];
  assign channel_selector = frame_in[`CLDC_CHANNEL_SELECTOR_HI:`CLDC_CHANNEL_SELECTOR_LO];
  assign is_write = frame_in[`CLDC_RW_BIT];

  // message code to frame kind
  function automatic cldc_kind_t decode_kind(input logic [3:0] c);
    case (c)
      `CLDC_CODE_GAIN: decode_kind = CLDC_K_GAIN;
      `CLDC_CODE_SETPT: decode_kind = CLDC_K_SETPT;
      `CLDC_CODE_DPER: decode_kind = CLDC_K_DPER;
      default: decode_kind = CLDC_K_NONE;
    endcase
  endfunction

  // unknown codes decode to none and store nothing
  assign kind = decode_kind(code);

  // ****************************************
  // register writes
  // ****************************************
  // gain registers
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < CHANNELS; i++) begin
        prop_gain_q[i] <= `CLDC_GAIN_RST;
        int_gain_q[i] <= `CLDC_GAIN_RST;
      end
    end else if (frame_valid && is_write && kind == CLDC_K_GAIN) begin
      prop_gain_q[channel_selector] <= frame_in[`CLDC_KP_HI:`CLDC_KP_LO];
      int_gain_q[channel_selector] <= frame_in[`CLDC_KI_HI:`CLDC_KI_LO];
    end
  end

  // setpoint, dither step and hold flag
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < CHANNELS; i++) begin
        setpoint_q[i] <= `CLDC_FIELD11_RST;
        dstep_q[i] <= `CLDC_FIELD11_RST;
        hold_q[i] <= 1'b0;
      end
    end else if (frame_valid && is_write && kind == CLDC_K_SETPT) begin
      hold_q[channel_selector] <= frame_in[`CLDC_HOLD_BIT];
      dstep_q[channel_selector] <= frame_in[`CLDC_STEP_HI:`CLDC_STEP_LO];
      setpoint_q[channel_selector] <= frame_in[`CLDC_SETP_HI:`CLDC_SETP_LO];
    end
  end

  // quarter-wave step count
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < CHANNELS; i++) begin
        qsteps_q[i] <= `CLDC_QSTEP_RST;
      end
    end else if (frame_valid && is_write && kind == CLDC_K_DPER) begin
      qsteps_q[channel_selector] <= frame_in[`CLDC_QSTEP_HI:`CLDC_QSTEP_LO];
    end
  end

  // ****************************************
  // response
  // ****************************************
  // answer built from stored values, registered one cycle after the frame
  // a write lands at the taking edge, so its answer shows the old value
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      resp_q <= 32'h00000000;
      resp_valid_q <= 1'b0;
    end else begin
      resp_valid_q <= frame_valid;
      if (frame_valid) begin
        resp_q <= 32'h00000000; // bit 31 and unused bits zero
        resp_q[`CLDC_CODE_HI:`CLDC_CODE_LO] <= code;
        resp_q[`CLDC_CHANNEL_SELECTOR_HI:`CLDC_CHANNEL_SELECTOR_LO] <= channel_selector;
        case (kind)
          CLDC_K_GAIN: begin
            resp_q[`CLDC_KP_HI:`CLDC_KP_LO] <= prop_gain_q[channel_selector];
            resp_q[`CLDC_KI_HI:`CLDC_KI_LO] <= int_gain_q[channel_selector];
          end
          CLDC_K_SETPT: begin
            resp_q[`CLDC_HOLD_BIT] <= hold_q[channel_selector];
            resp_q[`CLDC_STEP_HI:`CLDC_STEP_LO] <= dstep_q[channel_selector];
            resp_q[`CLDC_SETP_HI:`CLDC_SETP_LO] <= setpoint_q[channel_selector];
          end
          CLDC_K_DPER: begin
            resp_q[`CLDC_QSTEP_HI:`CLDC_QSTEP_LO] <= qsteps_q[channel_selector];
          end
          default: begin
            // unknown code: echo only
          end
        endcase
      end
    end
  end

  // outputs straight from the response flops
  assign resp_out = resp_q;
  assign resp_valid = resp_valid_q;

  // ****************************************
  // enable pin synchroniser
  // ****************************************
  // three stages, level taken once the last two agree
  // a one-cycle glitch on the pin never reaches the channel enables
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      en_sync_q <= 3'h0;
      enable_q <= 1'b0;
    end else begin
      en_sync_q <= {en_sync_q[1:0], enable_pin};
      if (en_sync_q[1] == en_sync_q[2]) begin
        enable_q <= en_sync_q[2];
      end
    end
  end

  // ****************************************
  // derived outputs for the control law
  // ****************************************
  // flatten stored values, channel i at i times the field width
  always_comb begin
    for (int i = 0; i < CHANNELS; i++) begin
      prop_gain_flat[i*12 +: 12] = prop_gain_q[i];
      int_gain_flat[i*12 +: 12] = int_gain_q[i];
      setpoint_flat[i*11 +: 11] = setpoint_q[i];
      channel_selector_active[i] = enable_q || hold_q[i];
      // zero step or zero count turns dither off
      dither_on[i] = (dstep_q[i] != 11'h000) && (qsteps_q[i] != 5'h00);
      // 2*step*count, lsb is 2^-13 of full scale
      // widen both factors first, an 11-bit product would wrap
      dither_pp_flat[i*18 +: 18] = {17'(dstep_q[i]) * 17'(qsteps_q[i]), 1'b0};
      // period in pwm periods
      dither_period_flat[i*7 +: 7] = {2'h0, qsteps_q[i]} * `CLDC_QUARTERS;
    end
  end

  // pwm period tick paces one dither step per period
  cldc_step_timer u_timer (
    .sys_clk(sys_clk),
    .rst(rst),
    .div_n(div_n),
    .div_m(div_m),
    .pwm_tick(pwm_tick)
  );
endmodule
`default_nettype wire

// *** verification/cldc_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// host side: one frame per call, driven on the falling edge
module cldc_host_model
  import cldc_pkg::*;
(
  // clock
  input wire logic sys_clk,
  // frame and response
  output logic frame_valid,
  output cldc_frame_t frame_in,
  input wire logic resp_valid,
  input wire logic [31:0] resp_out
);
  initial begin
    frame_valid = 1'b0;
    frame_in = 32'h0;
  end
  // hold across the taking edge, then release with inverted data
  task automatic send(input cldc_frame_t f, output logic v, output cldc_frame_t r);
    @(negedge sys_clk);
    frame_valid = 1'b1;
    frame_in = f;
    @(negedge sys_clk);
    frame_valid = 1'b0;
    frame_in = ~f;
    v = resp_valid;
    r = resp_out;
  endtask
endmodule
`default_nettype wire

// *** verification/cldc_config_bank_asserts.sv ***
`timescale 1ns/1ps
`default_nettype none
module cldc_config_bank_asserts #(
  parameter int CHANNELS = 8
)
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // frame side
  input wire logic frame_valid,
  input wire logic [31:0] frame_in,
  input wire logic resp_valid,
  input wire logic [31:0] resp_out,
  // stored values
  input wire logic [CHANNELS*12-1:0] prop_gain_flat,
  input wire logic [CHANNELS*12-1:0] int_gain_flat,
  input wire logic [CHANNELS*11-1:0] setpoint_flat,
  input wire logic [CHANNELS-1:0] dither_on,
  input wire logic [CHANNELS*18-1:0] dither_pp_flat,
  input wire logic [CHANNELS*7-1:0] dither_period_flat
);
  // write to channel 0, and the frame code
  logic wr0;
  logic [3:0] code;
  assign wr0 = frame_valid && frame_in[31] && frame_in[26:24] == 3'h0;
  assign code = frame_in[30:27];
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  resp_pulse_a: assert property (frame_valid |=> resp_valid)
    else $error("response missing");
  resp_single_a: assert property (!frame_valid |=> !resp_valid)
    else $error("stray response");
  echo_hdr_a: assert property (frame_valid |=> resp_out[31:24] == {1'b0, $past(frame_in[30:24])})
    else $error("header not echoed");
  dper_zero_a: assert property (frame_valid && code == 4'h4 |=> resp_out[23:5] == 19'h0)
    else $error("unused bits set");
  prop_store_a: assert property (wr0 && code == 4'h2 |=> prop_gain_flat[11:0] == $past(frame_in[23:12]))
    else $error("prop gain not stored");
  int_store_a: assert property (wr0 && code == 4'h2 |=> int_gain_flat[11:0] == $past(frame_in[11:0]))
    else $error("int gain not stored");
  setp_store_a: assert property (wr0 && code == 4'h3 |=> setpoint_flat[10:0] == $past(frame_in[10:0]))
    else $error("setpoint not stored");
  dper_store_a: assert property (wr0 && code == 4'h4 |=> dither_period_flat[6:0] == {$past(frame_in[4:0]), 2'h0})
    else $error("period not four counts");
  dith_on_a: assert property (dither_on[0] == (dither_pp_flat[17:0] != 18'h0))
    else $error("dither enable wrong");
  cover property (wr0 && code == 4'h2);
  cover property (frame_valid && !frame_in[31]);
  cover property (dither_on[0]);
endmodule
bind cldc_config_bank cldc_config_bank_asserts #(.CHANNELS(CHANNELS)) i_cldc_config_bank_asserts (
  .sys_clk, .rst, .frame_valid, .frame_in, .resp_valid, .resp_out, .prop_gain_flat,
  .int_gain_flat, .setpoint_flat, .dither_on, .dither_pp_flat, .dither_period_flat);
`default_nettype wire

// *** verification/cldc_config_bank_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module cldc_config_bank_tb
  import cldc_pkg::*;
;
  logic sys_clk, rst, frame_valid, resp_valid, enable_pin, pwm_tick, v;
  cldc_frame_t frame_in, resp_out, r;
  logic [13:0] div_n;
  logic [1:0] div_m;
  logic [95:0] prop_gain_flat, int_gain_flat;
  logic [87:0] setpoint_flat;
  logic [7:0] channel_selector_active, dither_on;
  logic [143:0] dither_pp_flat;
  logic [55:0] dither_period_flat;
  int mismatches = 0;
  int cmp_count = 0;
  cldc_host_model i_cldc_host_model (.sys_clk, .frame_valid, .frame_in, .resp_valid,
    .resp_out);
  cldc_config_bank i_cldc_config_bank (.sys_clk, .rst, .frame_valid, .frame_in, .resp_valid,
    .resp_out, .div_n, .div_m, .enable_pin, .prop_gain_flat, .int_gain_flat, .setpoint_flat,
    .channel_selector_active, .dither_on, .dither_pp_flat, .dither_period_flat, .pwm_tick);
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %s exp %h got %h", nm, exp, got);
    end
  endtask
  task final_report;
    if (mismatches == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // one frame, response header and data compared
  task automatic xf(input logic [7:0] hd, input logic [23:0] d, input logic [23:0] e);
    i_cldc_host_model.send({hd, d}, v, r);
    chk("resp_valid", v, 1'b1);
    chk("resp_out", r, {1'b0, hd[6:0], e});
  endtask
  // fields all zero after reset, reads give zero
  task automatic t_reset;
    chk("reset", |{prop_gain_flat, int_gain_flat, setpoint_flat, channel_selector_active}, 1'b0);
    xf(8'h15, 24'h0, 24'h0);
    xf(8'h25, 24'h0, 24'h0);
  endtask
  // every channel keeps its own gains
  task automatic t_gains;
    for (int c = 0; c < 8; c++) xf({5'h12, c[2:0]}, {9'h140, c[2:0], 9'hA0, c[2:0]}, 24'h0);
    for (int c = 0; c < 8; c++) begin
      xf({5'h02, c[2:0]}, 24'h0, {9'h140, c[2:0], 9'hA0, c[2:0]});
      chk("prop", prop_gain_flat[c*12+:12], {9'h140, c[2:0]});
      chk("int", int_gain_flat[c*12+:12], {9'hA0, c[2:0]});
    end
    xf(8'hAB, 24'hFFFFFF, 24'h0);
    chk("refused", prop_gain_flat[47:36], 12'hA03);
  endtask
  // setpoint, step and quarter count on channel 0
  task automatic t_dither;
    xf(8'h98, {2'h2, 11'h7FF, 11'h5A5}, 24'h0);
    chk("setpoint", setpoint_flat[10:0], 11'h5A5);
    chk("dither_off", dither_on[0], 1'b0);
    xf(8'hA0, 24'hFFFFFF, 24'h0);
    xf(8'h20, 24'h0, 24'h1F);
    chk("period", dither_period_flat[6:0], 7'h7C);
    chk("pp", dither_pp_flat[17:0], 18'h1EFC2);
    chk("dither_on", dither_on[0], 1'b1);
    xf(8'h98, {2'h2, 11'h0, 11'h5A5}, {2'h2, 11'h7FF, 11'h5A5});
    chk("step_zero", dither_on[0], 1'b0);
  endtask
  // enable pin against the hold flag of channel 0
  task automatic t_enable;
    enable_pin = 1'b1;
    repeat (5) @(negedge sys_clk);
    chk("active_on", channel_selector_active, 8'hFF);
    enable_pin = 1'b0;
    repeat (5) @(negedge sys_clk);
    chk("active_hold", channel_selector_active, 8'h01);
  endtask
  // clocks to the next pwm tick, bounded
  task automatic gap(output int n);
    n = 0;
    do begin
      @(negedge sys_clk);
      n++;
    end while (pwm_tick !== 1'b1 && n < 600);
    if (n >= 600) begin
      chk("tick_wait", 32'h0, 32'h1);
      final_report;
    end
  endtask
  task automatic t_tick;
    int n;
    gap(n);
    gap(n);
    chk("tick_gap", n, 256);
    // other m codes with n of three, first gap after a change is skipped
    div_n = 14'h3;
    div_m = 2'h0;
    gap(n);
    gap(n);
    chk("tick_m32", n, 96);
    div_m = 2'h1;
    gap(n);
    gap(n);
    chk("tick_m64", n, 192);
    div_m = 2'h2;
    gap(n);
    gap(n);
    chk("tick_m128", n, 384);
  endtask
  initial begin
    rst = 1'b1;
    enable_pin = 1'b0;
    div_n = 14'h2;
    div_m = 2'h3;
    repeat (12) @(negedge sys_clk);
    rst = 1'b0;
    t_reset;
    t_gains;
    t_dither;
    t_enable;
    t_tick;
    final_report;
  end
endmodule
`default_nettype wire
